// *** hw/ramp_waveform_timer.sv ***
// Summary of operation
// [RULE1] Enable bit changes only while the enable-ready flag reads one.
// [RULE2] Other control A bits are written only while enable is zero.
// [RULE3] Command strobes cross to the core when enabled and idle, then self-clear.
// [RULE4] Software checks command-ready before issuing a new command.
// [RULE5] Buffered compares are writable while running only when buffer-sync-ready.
// [RULE6] Buffered values reach the core on a sync command or on enabling.
// [RULE7] Auto-update: writing compare B clear high byte schedules end-of-cycle copy.
// [RULE8] Immediate sync copies the buffers once the command has crossed over.
// [RULE9] End-of-cycle sync copies the buffers at the end of the next cycle; the code copies at the first end of cycle after the request.
// [RULE10] Sync commands arriving while a copy is pending are ignored.
// [RULE11] Static control registers do not change while the timer is enabled.
// [RULE12] Status, counter and interrupt control are accessible at any time.
// [RULE13] Mode field picks four modes; cycle runs dead A, on A, dead B, on B.
// [RULE14] One ramp counts to B clear then restarts at zero; period B clear plus one.
// [RULE15] One ramp: B clear clears all outputs; out-of-range compares never act.
// [RULE16] Two ramp counts to A clear, resets, then to B clear, then restarts.
// [RULE17] Two ramp: set values above their clear value are never reached.
// [RULE18] Four ramp resets at A set, A clear, B set, B clear in turn.
// [RULE19] Dual slope counts B clear down to zero and back up again.
// [RULE20] Dual slope: output A set counting down, cleared counting up at A set.
// [RULE21] Dual slope: output B set counting up, cleared counting down at B set.
// [RULE22] Dual slope ignores the A clear compare value.
// [RULE23] Counter and all compare values are twelve bits wide.
// [RULE24] Dual slope starts at B clear counting down with output B low.
// [RULE25] One ramp: A set/clear and B set/clear drive their outputs at matches.
//
// Design decisions made here: the Wishbone register port and the address map.
module ramp_waveform_timer #(
   parameter int CNT_W = 12
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [ramp_timer_pkg::ADDR_W-1:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [ramp_timer_pkg::DATA_W-1:0] wb_dat_in,
   output logic [ramp_timer_pkg::DATA_W-1:0] wb_dat_out,
   output logic wb_ack_out,
   output logic waveform_output_a_out,
   output logic waveform_output_b_out
);
   import ramp_timer_pkg::*;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic req;
   logic wr_fire;
   logic enable;
   logic [CFG_A_W-1:0] cfg_a;
   wave_mode_t waveform_mode_select;
   logic auto_update_select;
   logic [INT_CONTROL_W-1:0] int_control;
   logic [2:0] en_cnt;
   logic core_en;
   logic core_start;
   command_t cmd_pend;
   command_t cmd_fly;
   logic [2:0] cmd_cnt;
   logic cmd_launch;
   logic cmd_arrive;
   logic eoc_pend;
   logic enable_ready_flag;
   logic command_ready_flag;
   logic buffer_sync_ready_flag;
   logic cmp_wr_ok;
   logic cmp_wr;
   logic [1:0] cmp_idx;
   logic auto_sched;
   logic copy_now;
   compare_set_t bank;
   compare_set_t active;
   logic [CNT_W-1:0] cnt;
   logic dir_up;
   cycle_state_t state;
   logic end_cycle;
   logic phase_b;
   logic [CNT_W-1:0] four_bound;
   logic [DATA_W-1:0] next_rdata;

   // ------------------------------------------------------------
   // Wishbone slave
   // ------------------------------------------------------------
   assign req = wb_cyc_in & wb_stb_in;
   // Writes land on the edge that samples ack, never earlier
   assign wr_fire = req & wb_ack_out & wb_we_in;

   // One wait cycle, ack for exactly one cycle
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wb_ack_out <= 1'b0;
      end else begin
         wb_ack_out <= req & ~wb_ack_out;
      end
   end

   // Read mux, registered so data and ack rise together
   always_comb begin
      next_rdata = '0;
      case (wb_adr_in)
         OFS_CONTROL_A: next_rdata[CFG_A_W:0] = {cfg_a, enable};
         OFS_CONTROL_B: next_rdata[1:0] = waveform_mode_select;
         OFS_CONTROL_C: next_rdata[AUTO_UPDATE_BIT] = auto_update_select;
         OFS_COMMAND: next_rdata[CMD_W-1:0] = cmd_pend;
         OFS_STATUS: begin // [RULE12]
            next_rdata[ST_ENABLE_READY_BIT] = enable_ready_flag;
            next_rdata[ST_COMMAND_READY_BIT] = command_ready_flag;
            next_rdata[ST_BUFFER_READY_BIT] = buffer_sync_ready_flag;
            next_rdata[ST_RUNNING_BIT] = core_en;
            next_rdata[ST_STATE_LSB +: 2] = state;
         end
         OFS_CMP_A_SET: next_rdata[CNT_W-1:0] = bank.a_set;
         OFS_CMP_A_CLR: next_rdata[CNT_W-1:0] = bank.a_clr;
         OFS_CMP_B_SET: next_rdata[CNT_W-1:0] = bank.b_set;
         OFS_CMP_B_CLR: next_rdata[CNT_W-1:0] = bank.b_clr;
         OFS_COUNTER: next_rdata[CNT_W-1:0] = cnt; // [RULE12]
         OFS_INT_CONTROL: next_rdata[INT_CONTROL_W-1:0] = int_control;
         default: next_rdata = '0; // Unmapped reads as zero
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wb_dat_out <= '0;
      end else if (req && !wb_ack_out) begin
         wb_dat_out <= next_rdata;
      end
   end

   // ------------------------------------------------------------
   // Control A: enable and protected configuration
   // ------------------------------------------------------------
   assign enable_ready_flag = (en_cnt == 3'h0);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         enable <= 1'b0;
         cfg_a <= CFG_A_RESET;
      end else if (wr_fire && wb_adr_in == OFS_CONTROL_A && wb_sel_in[0]) begin
         if (enable_ready_flag) begin
            enable <= wb_dat_in[ENABLE_BIT]; // [RULE1]
         end
         if (!enable) begin
            cfg_a <= wb_dat_in[CFG_A_LSB +: CFG_A_W]; // [RULE2]
         end
      end
   end

   // Enable crossing: core follows after SYNC_CYCLES, busy meanwhile
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         en_cnt <= 3'h0;
      end else if (wr_fire && wb_adr_in == OFS_CONTROL_A && wb_sel_in[0]
                   && enable_ready_flag) begin
         en_cnt <= SYNC_CYCLES; // [RULE1]
      end else if (en_cnt != 3'h0) begin
         en_cnt <= en_cnt - 3'h1;
      end
   end

   assign core_start = (en_cnt == 3'h1) && enable && !core_en;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         core_en <= 1'b0;
      end else if (en_cnt == 3'h1) begin
         core_en <= enable;
      end
   end

   // ------------------------------------------------------------
   // Static and normal registers
   // ------------------------------------------------------------
   // Frozen while enabled so the core never sees a mode change mid-cycle
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         waveform_mode_select <= MODE_ONE_RAMP;
         auto_update_select <= 1'b0;
      end else if (wr_fire && !enable && wb_sel_in[0]) begin // [RULE11]
         if (wb_adr_in == OFS_CONTROL_B) begin
            waveform_mode_select <= wave_mode_t'(wb_dat_in[MODE_LSB +: 2]); // [RULE13]
         end
         if (wb_adr_in == OFS_CONTROL_C) begin
            auto_update_select <= wb_dat_in[AUTO_UPDATE_BIT];
         end
      end
   end

   // Interrupt control is plain storage, writable at any time
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         int_control <= INT_CONTROL_RESET;
      end else if (wr_fire && wb_adr_in == OFS_INT_CONTROL && wb_sel_in[0]) begin
         int_control <= wb_dat_in[INT_CONTROL_W-1:0]; // [RULE12]
      end
   end

   // ------------------------------------------------------------
   // Command strobes
   // ------------------------------------------------------------
   assign cmd_launch = core_en && (cmd_cnt == 3'h0) && (cmd_pend != '0); // [RULE3]
   assign cmd_arrive = (cmd_cnt == 3'h1);
   assign command_ready_flag = (cmd_cnt == 3'h0) && (cmd_pend == '0);

   // New strobe bits win over the self-clear in the same cycle
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cmd_pend <= '0;
      end else begin
         if (cmd_launch) begin
            cmd_pend <= '0; // [RULE3]
         end
         if (wr_fire && wb_adr_in == OFS_COMMAND && wb_sel_in[0]) begin
            cmd_pend <= (cmd_launch ? command_t'('0) : cmd_pend)
                        | command_t'(wb_dat_in[CMD_W-1:0]);
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cmd_cnt <= 3'h0;
         cmd_fly <= '0;
      end else if (cmd_launch) begin
         cmd_cnt <= SYNC_CYCLES;
         cmd_fly <= cmd_pend;
      end else if (cmd_cnt != 3'h0) begin
         cmd_cnt <= cmd_cnt - 3'h1;
      end
   end

   // ------------------------------------------------------------
   // Double-buffered compares
   // ------------------------------------------------------------
   assign buffer_sync_ready_flag = !eoc_pend && (cmd_cnt == 3'h0);
   assign cmp_wr_ok = !enable || buffer_sync_ready_flag; // [RULE5]
   assign cmp_idx = 2'((wb_adr_in - OFS_CMP_A_SET) >> 2);
   assign cmp_wr = wr_fire && cmp_wr_ok && wb_adr_in >= OFS_CMP_A_SET
                   && wb_adr_in <= OFS_CMP_B_CLR;
   assign auto_sched = cmp_wr && core_en && auto_update_select
                       && wb_adr_in == OFS_CMP_B_CLR && wb_sel_in[1]; // [RULE7]
   // Immediate sync is dropped while an end-of-cycle copy is pending
   assign copy_now = cmd_arrive && cmd_fly.sync && !eoc_pend; // [RULE8] [RULE10]

   compare_shadow_bank #(
      .WIDTH(CNT_W)
   ) u_bank (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .wr_en_in(cmp_wr),
      .wr_idx_in(cmp_idx),
      .wr_sel_in(wb_sel_in[1:0]),
      .wr_data_in(wb_dat_in[CNT_W-1:0]),
      .bank_out(bank)
   );

   // Pending end-of-cycle copy; a new request wins over completion
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         eoc_pend <= 1'b0;
      end else if (!core_en) begin
         eoc_pend <= 1'b0;
      end else if (auto_sched || (cmd_arrive && cmd_fly.end_of_cycle)) begin
         eoc_pend <= 1'b1; // [RULE7] [RULE9] [RULE10]
      end else if (end_cycle) begin
         eoc_pend <= 1'b0; // [RULE9]
      end
   end

   // Active copy used by the counter core
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         active <= '0;
      end else if (core_start || copy_now || (eoc_pend && end_cycle)) begin
         active <= bank; // [RULE6] [RULE8] [RULE9]
      end
   end

   // ------------------------------------------------------------
   // Counter core
   // ------------------------------------------------------------
   assign phase_b = (state == DEAD_TIME_B) || (state == ON_TIME_B);

   // Four ramp limit depends on which quarter we are in
   always_comb begin
      case (state)
         DEAD_TIME_A: four_bound = active.a_set;
         ON_TIME_A: four_bound = active.a_clr;
         DEAD_TIME_B: four_bound = active.b_set;
         default: four_bound = active.b_clr;
      endcase
   end

   always_comb begin
      case (waveform_mode_select)
         MODE_ONE_RAMP: end_cycle = core_en && cnt == active.b_clr;
         MODE_TWO_RAMP: end_cycle = core_en && phase_b && cnt == active.b_clr;
         MODE_FOUR_RAMP: end_cycle = core_en && state == ON_TIME_B && cnt == active.b_clr;
         MODE_DUAL_SLOPE: end_cycle = core_en && dir_up && cnt == active.b_clr;
         default: end_cycle = 1'b0;
      endcase
   end

   // Restart and start clear outputs; dual slope starts at the top
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt <= '0;
         dir_up <= 1'b0;
         state <= DEAD_TIME_A;
         waveform_output_a_out <= 1'b0;
         waveform_output_b_out <= 1'b0;
      end else if (core_start || (core_en && cmd_arrive && cmd_fly.restart)) begin
         cnt <= (waveform_mode_select == MODE_DUAL_SLOPE) ?
                (core_start ? bank.b_clr : active.b_clr) : '0; // [RULE24]
         dir_up <= 1'b0;
         state <= DEAD_TIME_A;
         waveform_output_a_out <= 1'b0;
         waveform_output_b_out <= 1'b0; // [RULE24]
      end else if (!core_en) begin
         cnt <= '0;
         state <= DEAD_TIME_A;
         waveform_output_a_out <= 1'b0;
         waveform_output_b_out <= 1'b0;
      end else begin
         case (waveform_mode_select)
            MODE_ONE_RAMP: begin
               if (cnt == active.b_clr) begin
                  cnt <= '0; // [RULE14]
                  state <= DEAD_TIME_A;
                  waveform_output_a_out <= 1'b0; // [RULE15]
                  waveform_output_b_out <= 1'b0;
               end else begin
                  cnt <= cnt + 1'b1; // [RULE23]
                  if (cnt == active.a_set) begin
                     waveform_output_a_out <= 1'b1; // [RULE25]
                     state <= ON_TIME_A;
                  end
                  if (cnt == active.a_clr) begin
                     waveform_output_a_out <= 1'b0; // [RULE25] [RULE15]
                     state <= DEAD_TIME_B;
                  end
                  if (cnt == active.b_set) begin
                     waveform_output_b_out <= 1'b1; // [RULE25]
                     state <= ON_TIME_B;
                  end
               end
            end
            MODE_TWO_RAMP: begin
               if (!phase_b) begin
                  if (cnt == active.a_clr) begin
                     cnt <= '0; // [RULE16] [RULE17]
                     waveform_output_a_out <= 1'b0;
                     state <= DEAD_TIME_B;
                  end else begin
                     cnt <= cnt + 1'b1;
                     if (cnt == active.a_set) begin
                        waveform_output_a_out <= 1'b1;
                        state <= ON_TIME_A;
                     end
                  end
               end else if (cnt == active.b_clr) begin
                  cnt <= '0; // [RULE16]
                  waveform_output_b_out <= 1'b0;
                  state <= DEAD_TIME_A;
               end else begin
                  cnt <= cnt + 1'b1;
                  if (cnt == active.b_set) begin
                     waveform_output_b_out <= 1'b1; // [RULE17]
                     state <= ON_TIME_B;
                  end
               end
            end
            MODE_FOUR_RAMP: begin
               if (cnt == four_bound) begin
                  cnt <= '0; // [RULE18]
                  case (state)
                     DEAD_TIME_A: begin
                        state <= ON_TIME_A;
                        waveform_output_a_out <= 1'b1;
                     end
                     ON_TIME_A: begin
                        state <= DEAD_TIME_B;
                        waveform_output_a_out <= 1'b0;
                     end
                     DEAD_TIME_B: begin
                        state <= ON_TIME_B;
                        waveform_output_b_out <= 1'b1;
                     end
                     default: begin
                        state <= DEAD_TIME_A; // [RULE13]
                        waveform_output_b_out <= 1'b0;
                     end
                  endcase
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            MODE_DUAL_SLOPE: begin
               // A clear compare is never consulted here
               if (!dir_up) begin // [RULE22]
                  if (cnt == active.a_set) begin
                     waveform_output_a_out <= 1'b1; // [RULE20]
                     state <= ON_TIME_A;
                  end
                  if (cnt == active.b_set) begin
                     waveform_output_b_out <= 1'b0; // [RULE21]
                     state <= DEAD_TIME_A;
                  end
                  if (cnt == '0) begin
                     dir_up <= 1'b1; // [RULE19]
                  end else begin
                     cnt <= cnt - 1'b1;
                  end
               end else begin
                  if (cnt == active.a_set) begin
                     waveform_output_a_out <= 1'b0; // [RULE20]
                     state <= DEAD_TIME_B;
                  end
                  if (cnt == active.b_set) begin
                     waveform_output_b_out <= 1'b1; // [RULE21]
                     state <= ON_TIME_B;
                  end
                  if (cnt == active.b_clr) begin
                     dir_up <= 1'b0; // [RULE19]
                  end else begin
                     cnt <= cnt + 1'b1;
                  end
               end
            end
            default: cnt <= '0;
         endcase
      end
   end

endmodule // ramp_waveform_timer

// *** include/ramp_timer_pkg.sv ***
package ramp_timer_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int CNT_W = 12;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CONTROL_A = 8'h00;
   localparam logic [7:0] OFS_CONTROL_B = 8'h04;
   localparam logic [7:0] OFS_CONTROL_C = 8'h08;
   localparam logic [7:0] OFS_COMMAND = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_CMP_A_SET = 8'h14;
   localparam logic [7:0] OFS_CMP_A_CLR = 8'h18;
   localparam logic [7:0] OFS_CMP_B_SET = 8'h1C;
   localparam logic [7:0] OFS_CMP_B_CLR = 8'h20;
   localparam logic [7:0] OFS_COUNTER = 8'h24;
   localparam logic [7:0] OFS_INT_CONTROL = 8'h28;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int ENABLE_BIT = 0;
   localparam int CFG_A_LSB = 1;
   localparam int CFG_A_W = 7;
   localparam int MODE_LSB = 0;
   localparam int AUTO_UPDATE_BIT = 0;
   localparam int CMD_SYNC_BIT = 0;
   localparam int CMD_EOC_BIT = 1;
   localparam int CMD_RESTART_BIT = 2;
   localparam int CMD_W = 3;
   localparam int ST_ENABLE_READY_BIT = 0;
   localparam int ST_COMMAND_READY_BIT = 1;
   localparam int ST_BUFFER_READY_BIT = 2;
   localparam int ST_RUNNING_BIT = 3;
   localparam int ST_STATE_LSB = 4;
   localparam int INT_CONTROL_W = 8;

   // ------------------------------------------------------------
   // Reset values and timing
   // ------------------------------------------------------------
   localparam logic [CNT_W-1:0] CMP_RESET = 12'h000;
   localparam logic [CFG_A_W-1:0] CFG_A_RESET = 7'h00;
   localparam logic [INT_CONTROL_W-1:0] INT_CONTROL_RESET = 8'h00;
   // Cycles for one crossing into the core side
   localparam logic [2:0] SYNC_CYCLES = 3'h2;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {MODE_ONE_RAMP, MODE_TWO_RAMP, MODE_FOUR_RAMP, MODE_DUAL_SLOPE}
      wave_mode_t;
   typedef enum logic [1:0] {DEAD_TIME_A, ON_TIME_A, DEAD_TIME_B, ON_TIME_B} cycle_state_t;
   typedef struct packed {
      logic [CNT_W-1:0] a_set;
      logic [CNT_W-1:0] a_clr;
      logic [CNT_W-1:0] b_set;
      logic [CNT_W-1:0] b_clr;
   } compare_set_t;
   typedef struct packed {
      logic restart;
      logic end_of_cycle;
      logic sync;
   } command_t;

endpackage

// *** hw/compare_shadow_bank.sv ***
module compare_shadow_bank #(
   parameter int WIDTH = 12
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic wr_en_in,
   input wire logic [1:0] wr_idx_in,
   input wire logic [1:0] wr_sel_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   output ramp_timer_pkg::compare_set_t bank_out
);
   import ramp_timer_pkg::*;

   logic [3:0][WIDTH-1:0] mem;

   // ------------------------------------------------------------
   // Entries: 0 A set, 1 A clear, 2 B set, 3 B clear
   // ------------------------------------------------------------
   for (genvar i = 0; i < 4; i++) begin : g_entry
      // Low byte and upper nibble written by their own byte lane
      always_ff @(posedge clk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            mem[i] <= CMP_RESET;
         end else if (wr_en_in && wr_idx_in == 2'(i)) begin
            if (wr_sel_in[0]) begin
               mem[i][7:0] <= wr_data_in[7:0];
            end
            if (wr_sel_in[1]) begin
               mem[i][WIDTH-1:8] <= wr_data_in[WIDTH-1:8];
            end
         end
      end
   end

   assign bank_out = compare_set_t'({mem[0], mem[1], mem[2], mem[3]});

endmodule // compare_shadow_bank

// *** bench/gate_driver_model.sv ***
module gate_driver_model (
   input wire logic clk_in,
   input wire logic clear_in,
   input wire logic gate_a_in,
   input wire logic gate_b_in,
   output int on_a_out,
   output int on_b_out,
   output int rise_a_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic last_a = 1'b0;
   // Gate stage integrates levels and counts A rises; it never drives back
   always @(posedge clk_in) begin
      last_a <= gate_a_in;
      on_a_out <= clear_in ? 0 : on_a_out + int'(gate_a_in);
      on_b_out <= clear_in ? 0 : on_b_out + int'(gate_b_in);
      rise_a_out <= clear_in ? 0 : rise_a_out + int'(gate_a_in && !last_a);
   end
endmodule // gate_driver_model

// *** bench/timer_checker_asserts.sv ***
module timer_checker import ramp_timer_pkg::*; #(
   parameter int CNT_W = 12
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic wb_ack_out,
   input wire logic waveform_output_a_out,
   input wire logic waveform_output_b_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // Request taken at this edge; read answered at this edge
   wire logic req = wb_cyc_in && wb_stb_in && !wb_ack_out;
   wire logic rd = wb_ack_out && !wb_we_in;
   // -------------------
   // Bus and outputs
   // -------------------
   a_ack_next: assert property (req |=> wb_ack_out) else $error("ack late");
   a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack long");
   a_ack_cause: assert property (wb_ack_out |-> $past(req)) else $error("ack stray");
   a_ack_held: assert property (wb_ack_out |-> wb_cyc_in && wb_stb_in)
      else $error("ack idle");
   a_hole_zero: assert property (rd && wb_adr_in == 8'h3C |-> wb_dat_out == 32'h0)
      else $error("hole read");
   a_count_width: assert property (rd && wb_adr_in == OFS_COUNTER |->
      wb_dat_out[31:CNT_W] == '0) else $error("count wide");
   a_data_hold: assert property (!req |=> $stable(wb_dat_out)) else $error("data moved");
   a_reset_low: assert property ($rose(rst_n_in) |->
      !waveform_output_a_out && !waveform_output_b_out) else $error("out high");
   c_a_on: cover property ($rose(waveform_output_a_out));
   c_b_on: cover property ($rose(waveform_output_b_out));
   c_both_on: cover property (waveform_output_a_out && waveform_output_b_out);
endmodule // timer_checker
bind ramp_waveform_timer timer_checker #(.CNT_W(CNT_W)) u_chk (.clk_in(clk_in),
   .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
   .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
   .waveform_output_a_out(waveform_output_a_out),
   .waveform_output_b_out(waveform_output_b_out));

// *** bench/tb.sv ***
module tb import ramp_timer_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 1'b0, rst_n_in = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, clr = 1'b0;
   logic ack, wa, wb_o;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0, q, rdata;
   int on_a, on_b, rise_a, fails = 0, samples_checked = 0;
   always #20 clk_in = ~clk_in;
   ramp_waveform_timer dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc),
      .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(dat),
      .wb_dat_out(rdata), .wb_ack_out(ack), .waveform_output_a_out(wa),
      .waveform_output_b_out(wb_o));
   gate_driver_model gdm (.clk_in(clk_in), .clear_in(clr), .gate_a_in(wa),
      .gate_b_in(wb_o), .on_a_out(on_a), .on_b_out(on_b), .rise_a_out(rise_a));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One classic cycle; hangs are cut after 20 edges
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
      do begin
         @(posedge clk_in);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdata;
      {cyc, stb} <= 2'b00;
      if (n >= 20) begin
         fails++;
         conclude();
      end
   endtask
   task automatic wait_rdy(input int b);
      int n;
      q = 32'h0;
      for (n = 0; n < 50 && q[b] !== 1'b1; n++) bus(1'b0, OFS_STATUS, 32'h0);
      if (q[b] !== 1'b1) begin
         fails++;
         conclude();
      end
   endtask
   // Counts over whole periods, so the phase of the window does not matter
   task automatic measure(input int w);
      @(posedge clk_in);
      clr <= 1'b1;
      @(posedge clk_in);
      clr <= 1'b0;
      repeat (w) @(posedge clk_in);
      #1;
   endtask
   function automatic void expect_of(input int k, input int r, output int p, ea, eb);
      case (k)
         0: {p, ea, eb} = {4 * r + 2, r, r + 1};
         1: {p, ea, eb} = {6 * r + 3, r, r + 1};
         2: {p, ea, eb} = {10 * r + 5, 2 * r + 1, 4 * r + 2};
         default: {p, ea, eb} = {8 * r + 4, 4 * r + 1, 6 * r + 3};
      endcase
   endfunction
   // Dual slope takes A set above B set, so both outputs overlap
   task automatic start(input int k, input int r);
      int v[4];
      v = '{(k == 3) ? 2 * r : r, (k == 3) ? $urandom_range(4095) : 2 * r,
         (k == 3) ? r : 3 * r, 4 * r + 1};
      wait_rdy(ST_ENABLE_READY_BIT);
      bus(1'b1, OFS_CONTROL_A, 32'h0);
      bus(1'b1, OFS_CONTROL_B, 32'(k));
      foreach (v[i]) bus(1'b1, OFS_CMP_A_SET + 8'(4 * i), 32'(v[i]));
      wait_rdy(ST_ENABLE_READY_BIT);
      bus(1'b1, OFS_CONTROL_A, 32'h1);
   endtask
   task automatic static_and_sync(input int r, input int p);
      bus(1'b1, OFS_CONTROL_B, 32'h3);
      bus(1'b0, OFS_CONTROL_B, 32'h0);
      check(q, 32'h0);
      bus(1'b1, OFS_CONTROL_A, 32'hFF);
      bus(1'b0, OFS_CONTROL_A, 32'h0);
      check(q, 32'h1);
      bus(1'b0, OFS_COUNTER, 32'h0);
      check(32'(q < 32'(p)), 32'h1);
      wait_rdy(ST_BUFFER_READY_BIT);
      bus(1'b1, OFS_CMP_B_CLR, 32'(4 * r + 5));
      measure(3 * p);
      check(32'(on_b), 32'(3 * r + 3));
      wait_rdy(ST_COMMAND_READY_BIT);
      bus(1'b1, OFS_COMMAND, 32'h1);
      repeat (2 * p + 20) @(posedge clk_in);
      bus(1'b0, OFS_COMMAND, 32'h0);
      check(q, 32'h0);
      measure(3 * p + 12);
      check(32'(on_b), 32'(3 * r + 15));
   endtask
   initial begin
      int r, p, ea, eb;
      r = $urandom(32'h2C6F);
      repeat (5) @(posedge clk_in);
      rst_n_in <= 1'b1;
      bus(1'b0, OFS_CMP_B_CLR, 32'h0);
      check(q, 32'(CMP_RESET));
      bus(1'b0, 8'h3C, 32'h0);
      check(q, 32'h0);
      r = $urandom_range(255);
      bus(1'b1, OFS_INT_CONTROL, 32'(r));
      bus(1'b0, OFS_INT_CONTROL, 32'h0);
      check(q, 32'(r));
      for (int k = 0; k < 4; k++) begin
         r = $urandom_range(6, 2);
         start(k, r);
         expect_of(k, r, p, ea, eb);
         repeat (2 * p + 9) @(posedge clk_in);
         measure(3 * p);
         check(32'(rise_a), 32'h3);
         check(32'(on_a), 32'(3 * ea));
         check(32'(on_b), 32'(3 * eb));
         if (k == 0) static_and_sync(r, p);
      end
      conclude();
   end
endmodule // tb
